/* File: rtl/startup_pkg.sv */
// Notes on behaviour
// R1: Master clock 2.5 MHz, selected rate after 60 bytes
// R2: Start-up clock from config, user or scan
// R3: Eight phases, advancing in order after configuration
// R4: Internal end flag set in last phase
// R5: Setting picks phase releasing completion pin
// R6: Completion phase waits until pin seen high
// R7: Completion wait never delays earlier global releases
// R8: Setting picks set/reset release phase; holds flops
// R9: Setting picks write-enable phase; lock loops unaffected
// R10: Setting picks tristate release phase; outputs disabled
// R11: Follow-pin globals change on pin rise, pipelined
// R12: Pipeline option adds register on completion pin
// R13: Lock-wait phase holds until selected lock
// R14: Persistence keeps byte port, else pins user
// R15: Completion pin open-drain unless active drive set
// R16: Scan port always active, limited by security
// R17: Level one blocks all readback
// R18: Level two blocks configuration and readback
// R19: Security cleared only by deconfiguration
// R20: Scan user code returns 32-bit identifier
// R21: Start by commands, stray clock edges harmless
// R22: Configurer may make globals follow the pin
// R23: Start only after good CRC, else fail
// R24: At most one phase per start-up clock edge
package startup_pkg;
  localparam int CLK_KHZ       = 40000;
  localparam int KHZ_PER_MHZ   = 1000;
  localparam int INIT_RATE_KHZ = 2500;
  localparam int HALF_W        = 5;
  localparam int HALF_MAX      = 31;
  localparam int INIT_HALF     = CLK_KHZ / (2 * INIT_RATE_KHZ);
  localparam logic [5:0] SWITCH_BYTES = 6'h3c;
  localparam logic [2:0] PHASE_LAST   = 3'h7;

  localparam logic [7:0] OFS_CLOCK  = 8'h00;
  localparam logic [7:0] OFS_PHASE  = 8'h04;
  localparam logic [7:0] OFS_RATE   = 8'h08;
  localparam logic [7:0] OFS_SECURE = 8'h0c;
  localparam logic [7:0] OFS_USER_IDENTIFIER_WORD = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  localparam int CLK_SEL_LSB = 0;
  localparam int PIPE_BIT    = 2;
  localparam int DRIVE_BIT   = 3;
  localparam int MASTER_BIT  = 4;
  localparam int DONE_LSB    = 0;
  localparam int GTS_LSB     = 4;
  localparam int GTS_FOLLOW  = 7;
  localparam int GSR_LSB     = 8;
  localparam int GSR_FOLLOW  = 11;
  localparam int GWE_LSB     = 12;
  localparam int GWE_FOLLOW  = 15;
  localparam int LCK_LSB     = 16;
  localparam int NO_LOCK_WAIT_BIT  = 19;
  localparam int DLL_LSB     = 20;
  localparam int SEC_LSB     = 0;
  localparam int RETAIN_BIT  = 2;
  localparam int ST_STATE_LSB = 4;
  localparam int ST_DONE_SEEN = 8;
  localparam int ST_GTS       = 9;
  localparam int ST_GWE       = 10;
  localparam int ST_GSR       = 11;
  localparam int ST_RATE_SW   = 12;
  localparam int ST_SEC_LSB   = 16;

  localparam logic [31:0] CLOCK_RST = 32'h0000_0000;
  localparam logic [31:0] PHASE_RST = 32'h0008_6654;
  localparam logic [5:0]  RATE_RST  = 6'h04;

  localparam logic [1:0] SEC_NONE = 2'h0;
  localparam logic [1:0] SEC_L1   = 2'h1;
  localparam logic [1:0] SEC_L2   = 2'h2;
  localparam logic [1:0] SEL_CFG  = 2'h0;
  localparam logic [1:0] SEL_USER = 2'h1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_ARMED = 3'b001,
    S_RUN   = 3'b010,
    S_END   = 3'b011,
    S_FAIL  = 3'b100
  } seq_state_t;
endpackage

/* File: rtl/fpga_startup_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module fpga_startup_sequencer
  import startup_pkg::*;
#(
  parameter int          ADDR_W  = 8,
  parameter logic [31:0] USER_ID = 32'h1234_5678 // Arbitrary value
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              program_n,
  input  wire logic              configuration_clock_in,
  input  wire logic              design_clock_source,
  input  wire logic              scan_clock_source,
  input  wire logic              load_byte_strobe,
  input  wire logic              startup_command,
  input  wire logic              crc_final_valid,
  input  wire logic              crc_final_ok,
  input  wire logic              done_in,
  input  wire logic [3:0]        dll_locked,
  output var  logic              configuration_clock_o,
  output var  logic              configuration_clock_oe,
  output var  logic              done_o,
  output var  logic              done_oe,
  output var  logic              init_o,
  output var  logic              init_oe,
  output var  logic              global_output_tristate,
  output var  logic              global_write_enable,
  output var  logic              global_set_reset,
  output var  logic              end_of_startup_flag,
  output var  logic [31:0]       user_identifier_word,
  output var  logic              scan_config_allow,
  output var  logic              scan_readback_allow,
  output var  logic              byte_port_active,
  output var  logic              byte_port_config_allow,
  output var  logic              byte_port_readback_allow,
  output var  logic              config_pins_user_io
);

  if (ADDR_W < 8) begin : g_chk
    $error("ADDR_W must be at least 8");
  end

  logic [31:0]       clock_cfg_q;
  logic [31:0]       phase_cfg_q;
  logic [5:0]        rate_q;
  logic [1:0]        sec_q;
  logic              retain_q;
  logic              aw_full_q;
  logic              w_full_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic [5:0]        bytes_q;
  logic              rate_sw_q;
  logic [HALF_W-1:0] div_q;
  logic              src_prev_q;
  logic              done_pipe_q;
  seq_state_t        state_q;
  logic [2:0]        phase_q;

  // Config word fields
  logic [1:0] clk_sel;
  logic       pipe_on;
  logic       drive_on;
  logic       master_on;
  logic [2:0] done_ph;
  logic [2:0] gts_ph;
  logic [2:0] gsr_ph;
  logic [2:0] gwe_ph;
  logic [2:0] lck_ph;
  logic [1:0] dll_sel;
  logic       no_wait;
  assign clk_sel   = clock_cfg_q[CLK_SEL_LSB +: 2];
  assign pipe_on   = clock_cfg_q[PIPE_BIT];
  assign drive_on  = clock_cfg_q[DRIVE_BIT];
  assign master_on = clock_cfg_q[MASTER_BIT];
  assign done_ph   = phase_cfg_q[DONE_LSB +: 3];
  assign gts_ph    = phase_cfg_q[GTS_LSB +: 3];
  assign gsr_ph    = phase_cfg_q[GSR_LSB +: 3];
  assign gwe_ph    = phase_cfg_q[GWE_LSB +: 3];
  assign lck_ph    = phase_cfg_q[LCK_LSB +: 3];
  assign dll_sel   = phase_cfg_q[DLL_LSB +: 2];
  assign no_wait   = phase_cfg_q[NO_LOCK_WAIT_BIT];

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Smallest half period within the rate
  function automatic logic [HALF_W-1:0] half_for(input logic [5:0] r);
    logic [HALF_W-1:0] h;
    h = HALF_W'(HALF_MAX);
    for (int i = HALF_MAX; i >= 1; i--) begin
      if (2 * i * int'(r) * KHZ_PER_MHZ >= CLK_KHZ) begin
        h = HALF_W'(i);
      end
    end
    return h;
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0]        ofs);
    return a[ADDR_W-1:2] == (ADDR_W-2)'(ofs >> 2);
  endfunction

  logic wr_go;
  logic ar_take;
  assign wr_go   = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign ar_take = s_axi_arvalid & s_axi_arready;

  // Write channel: AW and W in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (hit(awaddr_q, OFS_CLOCK) || hit(awaddr_q, OFS_PHASE) ||
                         hit(awaddr_q, OFS_RATE) || hit(awaddr_q, OFS_SECURE) ||
                         hit(awaddr_q, OFS_USER_IDENTIFIER_WORD)) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Config registers; level two freezes them
  logic cfg_wr;
  assign cfg_wr = wr_go && (sec_q != SEC_L2); // see R18

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_cfg_q          <= CLOCK_RST;
      phase_cfg_q          <= PHASE_RST;
      rate_q               <= RATE_RST;
      retain_q             <= 1'b0;
      user_identifier_word <= USER_ID;
    end else if (cfg_wr) begin
      if (hit(awaddr_q, OFS_CLOCK)) begin
        clock_cfg_q <= merge(clock_cfg_q, wdata_q, wstrb_q);    // see R2
      end
      if (hit(awaddr_q, OFS_PHASE)) begin
        phase_cfg_q <= merge(phase_cfg_q, wdata_q, wstrb_q);    // see R5
      end
      if (hit(awaddr_q, OFS_RATE) && wstrb_q[0]) begin
        rate_q <= wdata_q[5:0];
      end
      if (hit(awaddr_q, OFS_SECURE) && wstrb_q[0]) begin
        retain_q <= wdata_q[RETAIN_BIT];
      end
      if (hit(awaddr_q, OFS_USER_IDENTIFIER_WORD)) begin
        user_identifier_word <= merge(user_identifier_word, wdata_q, wstrb_q); // see R20
      end
    end
  end

  // Security only climbs
  always_ff @(posedge aclk) begin
    if (!aresetn || !program_n) begin
      sec_q <= SEC_NONE; // see R19
    end else if (wr_go && hit(awaddr_q, OFS_SECURE) && wstrb_q[0] &&
                 wdata_q[SEC_LSB +: 2] > sec_q &&
                 wdata_q[SEC_LSB +: 2] <= SEC_L2) begin
      sec_q <= wdata_q[SEC_LSB +: 2];
    end
  end

  // Read channel
  logic [31:0] rd_data;
  logic        rd_err;
  logic        done_seen;
  always_comb begin
    rd_data = '0;
    rd_err  = 1'b0;
    if (hit(s_axi_araddr, OFS_CLOCK)) begin
      rd_data = clock_cfg_q;
    end else if (hit(s_axi_araddr, OFS_PHASE)) begin
      rd_data = phase_cfg_q;
    end else if (hit(s_axi_araddr, OFS_RATE)) begin
      rd_data[5:0] = rate_q;
    end else if (hit(s_axi_araddr, OFS_SECURE)) begin
      rd_data[SEC_LSB +: 2] = sec_q;
      rd_data[RETAIN_BIT]   = retain_q;
    end else if (hit(s_axi_araddr, OFS_USER_IDENTIFIER_WORD)) begin
      rd_data = user_identifier_word;
    end else if (hit(s_axi_araddr, OFS_STATUS)) begin
      // End flag absent: internal only
      rd_data[2:0] = phase_q; // see R4
      rd_data[ST_STATE_LSB +: 3] = state_q;
      rd_data[ST_DONE_SEEN] = done_seen;
      rd_data[ST_GTS] = global_output_tristate;
      rd_data[ST_GWE] = global_write_enable;
      rd_data[ST_GSR] = global_set_reset;
      rd_data[ST_RATE_SW] = rate_sw_q;
      rd_data[ST_SEC_LSB +: 2] = sec_q;
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Loaded bytes pick master rate
  always_ff @(posedge aclk) begin
    if (!aresetn || !program_n) begin
      bytes_q   <= '0;
      rate_sw_q <= 1'b0;
    end else if (load_byte_strobe && !rate_sw_q) begin
      bytes_q   <= bytes_q + 6'h01;
      rate_sw_q <= (bytes_q + 6'h01) == SWITCH_BYTES; // see R1
    end
  end

  logic [HALF_W-1:0] half;
  assign half = rate_sw_q ? half_for(rate_q) : HALF_W'(INIT_HALF); // see R1

  always_ff @(posedge aclk) begin
    if (!aresetn || !program_n || !master_on) begin
      div_q                 <= '0;
      configuration_clock_o <= 1'b0;
    end else if (div_q >= half - HALF_W'(1)) begin
      div_q                 <= '0;
      configuration_clock_o <= ~configuration_clock_o;
    end else begin
      div_q <= div_q + HALF_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      configuration_clock_oe <= 1'b0;
    end else begin
      configuration_clock_oe <= master_on;
    end
  end

  // Start-up clock; a rising edge is one step
  logic src_now;
  logic step;
  always_comb begin
    case (clk_sel)
      SEL_CFG:  src_now = master_on ? configuration_clock_o
                                    : configuration_clock_in;  // see R2
      SEL_USER: src_now = design_clock_source;
      default:  src_now = scan_clock_source;
    endcase
  end
  assign step = src_now & ~src_prev_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src_now;
    end
  end

  // Trades one start-up clock of latency for slow pin rise
  always_ff @(posedge aclk) begin
    if (!aresetn || !program_n) begin
      done_pipe_q <= 1'b0;
    end else if (step) begin
      done_pipe_q <= done_in; // see R12
    end
  end

  logic lock_ok;
  logic hold;
  logic started;
  logic released;
  assign done_seen = pipe_on ? done_pipe_q : done_in;           // see R12
  assign lock_ok   = dll_locked[dll_sel];
  assign hold      = (phase_q == done_ph && !done_seen) ||      // see R6
                     (!no_wait && phase_q == lck_ph && !lock_ok); // see R13
  assign started   = (state_q == S_RUN) || (state_q == S_END);
  assign released  = started && (phase_q >= done_ph); // see R5

  // Only commands start it; idle clock edges do nothing
  always_ff @(posedge aclk) begin
    if (!aresetn || !program_n) begin
      state_q             <= S_IDLE;
      phase_q             <= '0;
      end_of_startup_flag <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (crc_final_valid && !crc_final_ok) begin
            state_q <= S_FAIL; // see R23
          end else if (startup_command) begin
            state_q <= S_ARMED; // see R21
          end
        end
        S_ARMED: begin
          if (crc_final_valid) begin
            state_q <= crc_final_ok ? S_RUN : S_FAIL; // see R23
          end
        end
        S_RUN: begin
          if (step && !hold) begin // see R24
            phase_q <= phase_q + 3'h1; // see R3
            if (phase_q == PHASE_LAST - 3'h1) begin
              state_q             <= S_END;
              end_of_startup_flag <= 1'b1; // see R4
            end
          end
        end
        S_END:   state_q <= S_END;
        S_FAIL:  state_q <= S_FAIL;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Fault line low on CRC failure or deconfigure
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_o  <= 1'b0;
      init_oe <= 1'b0;
    end else begin
      init_o  <= 1'b0;
      init_oe <= !program_n || (state_q == S_FAIL); // see R23
    end
  end

  // Open drain holds low until release; active drive also pulls high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_o  <= 1'b0;
      done_oe <= 1'b1;
    end else begin
      done_o  <= released && drive_on; // see R15
      done_oe <= !released || drive_on; // see R15
    end
  end

  // Phase-timed globals up to the completion phase ignore the pin wait
  function automatic logic rel(input logic [2:0] ph, input logic fol);
    return fol ? (started && done_seen) // see R11
               : (started && phase_q >= ph); // see R7
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn || !program_n) begin
      global_output_tristate <= 1'b1;
      global_set_reset       <= 1'b1;
      global_write_enable    <= 1'b0;
    end else begin
      global_output_tristate <= !rel(gts_ph, phase_cfg_q[GTS_FOLLOW]); // see R10
      global_set_reset       <= !rel(gsr_ph, phase_cfg_q[GSR_FOLLOW]); // see R8
      global_write_enable    <= rel(gwe_ph, phase_cfg_q[GWE_FOLLOW]);  // see R9
    end
  end

  // Scan port stays alive whatever the persistence
  logic bp_on;
  assign bp_on = (state_q != S_END) || retain_q; // see R14

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_config_allow        <= 1'b1;
      scan_readback_allow      <= 1'b1;
      byte_port_active         <= 1'b1;
      byte_port_config_allow   <= 1'b1;
      byte_port_readback_allow <= 1'b1;
      config_pins_user_io      <= 1'b0;
    end else begin
      scan_config_allow        <= sec_q != SEC_L2; // see R16
      scan_readback_allow      <= sec_q == SEC_NONE; // see R17
      byte_port_active         <= bp_on;
      byte_port_config_allow   <= bp_on && (sec_q != SEC_L2);   // see R18
      byte_port_readback_allow <= bp_on && (sec_q == SEC_NONE); // see R17
      config_pins_user_io      <= (state_q == S_END) && !retain_q; // see R14
    end
  end

endmodule
`default_nettype wire

/* File: tb/startup_props.sv */
`timescale 1ns/1ps
`default_nettype none
module startup_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        program_n,
  input wire logic        init_o,
  input wire logic        init_oe,
  input wire logic        end_of_startup_flag,
  input wire logic        scan_config_allow,
  input wire logic        scan_readback_allow,
  input wire logic        byte_port_readback_allow
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp moved");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata moved");
  rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read");
  wr_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("late write");
  init_drain_a: assert property (init_oe |-> !init_o)
    else $error("init high");
  prog_init_a: assert property (!program_n |-> ##[1:2] init_oe)
    else $error("init idle");
  eos_keep_a: assert property (end_of_startup_flag && program_n ##1 program_n |-> end_of_startup_flag)
    else $error("end flag lost");
  sec_keep_a: assert property (!scan_config_allow && program_n ##1 program_n |-> !scan_config_allow)
    else $error("lock lifted");
  rb_block_a: assert property (!scan_config_allow |-> !scan_readback_allow && !byte_port_readback_allow)
    else $error("readback open");
  cover property (end_of_startup_flag);
  cover property (!scan_config_allow);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind fpga_startup_sequencer startup_props u_props (.*);
`default_nettype wire

/* File: tb/completion_line_model.sv */
`timescale 1ns/1ps
`default_nettype none
module completion_line_model (
  input  wire logic done_o,
  input  wire logic done_oe,
  input  wire logic hold_low,
  output wire logic done_in
);
  // Shared line with pull-up; another device may still sink it
  assign done_in = (done_oe ? done_o : 1'b1) & !hold_low;
endmodule
`default_nettype wire

/* File: tb/test_fpga_startup_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module test_fpga_startup_sequencer;
  import startup_pkg::*;
  localparam logic [31:0] UID = 32'h0bad_f00d; // Arbitrary value
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, program_n, configuration_clock_in, design_clock_source;
  logic        scan_clock_source, load_byte_strobe, startup_command, crc_final_valid;
  logic        crc_final_ok, done_in, configuration_clock_o, configuration_clock_oe, done_o;
  logic        done_oe, init_o, init_oe, global_output_tristate, global_write_enable;
  logic        global_set_reset, end_of_startup_flag, scan_config_allow, scan_readback_allow;
  logic        byte_port_active, byte_port_config_allow, byte_port_readback_allow;
  logic        config_pins_user_io, hold_low, lk;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, user_identifier_word, rs;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb, dll_locked;
  logic [65:0] q[$];
  logic [65:0] e;
  int          err_count, n_tests;

  fpga_startup_sequencer #(.USER_ID(UID)) dut_u (.*);
  completion_line_model line_u (.done_o(done_o), .done_oe(done_oe), .hold_low(hold_low),
                                .done_in(done_in));

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  task automatic end_of_test;
    if (err_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic chb(input string nm, input logic seen, input logic exp);
    chk(nm, {31'h0, seen}, {31'h0, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w;
    @(posedge aclk);
    q.push_back({r, 32'h0, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      aw = aw && (s_axi_awready !== 1'b1);
      w = w && (s_axi_wready !== 1'b1);
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge aclk);
    q.push_back({r, m, d & m});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask

  task automatic step(input int n);
    repeat (n) begin
      @(posedge aclk) configuration_clock_in <= 1'b1;
      repeat (3) @(posedge aclk);
      configuration_clock_in <= 1'b0;
      repeat (3) @(posedge aclk);
    end
  endtask

  task automatic go(input logic ok);
    @(posedge aclk) startup_command <= 1'b1;
    @(posedge aclk) startup_command <= 1'b0;
    crc_final_valid <= 1'b1;
    crc_final_ok <= ok;
    @(posedge aclk) crc_final_valid <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic prog;
    @(posedge aclk) program_n <= 1'b0;
    repeat (4) @(posedge aclk);
    program_n <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask

  task automatic bytes(input int n);
    repeat (n) begin
      @(posedge aclk) load_byte_strobe <= 1'b1;
      @(posedge aclk) load_byte_strobe <= 1'b0;
    end
  endtask

  // First pass aligns to a rising edge
  task automatic per(input int exp);
    int n;
    repeat (2) begin
      n = 0;
      while (configuration_clock_o === 1'b1) @(posedge aclk) n++;
      while (configuration_clock_o === 1'b0) @(posedge aclk) n++;
    end
    chk("master period", n, exp);
  endtask

  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      e = q.pop_front();
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, e[65:64]});
    end
    if (s_axi_rvalid && s_axi_rready) begin
      e = q.pop_front();
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, e[65:64]});
      chk("rdata", s_axi_rdata & e[63:32], e[31:0]);
    end
  end

  // Unselected clocks toggle at random to prove they are ignored
  always @(posedge aclk) begin
    rs <= xs(rs);
    design_clock_source <= rs[0];
    scan_clock_source <= rs[1];
    dll_locked <= {rs[3:2], lk, rs[4]};
  end

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    end_of_test();
  end

  initial begin
    rs = 32'h3f716f25;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {configuration_clock_in, load_byte_strobe, startup_command, crc_final_valid} = '0;
    {crc_final_ok, lk, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {design_clock_source, scan_clock_source, dll_locked} = '0;
    s_axi_wstrb = 4'hf;
    program_n = 1'b1;
    hold_low = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    step(3);
    rd(OFS_STATUS, 32'hffff_ffff, 32'h0000_0a00, RESP_OKAY);
    rd(OFS_PHASE, 32'hffff_ffff, PHASE_RST, RESP_OKAY);
    rd(OFS_RATE, 32'h0000_003f, {26'h0, RATE_RST}, RESP_OKAY);
    rd(OFS_USER_IDENTIFIER_WORD, 32'hffff_ffff, UID, RESP_OKAY);
    chk("user word", user_identifier_word, UID);
    rd(8'h20, 32'hffff_ffff, 32'h0, RESP_SLVERR);
    wr(OFS_STATUS, 32'h0, RESP_SLVERR);
    wr(OFS_PHASE, 32'h0008_3324, RESP_OKAY);
    go(1'b1);
    step(1);
    chb("tristate 1", global_output_tristate, 1'b1);
    step(5);
    rd(OFS_STATUS, 32'h7, 32'h4, RESP_OKAY);
    chb("done released", done_oe, 1'b0);
    chb("tristate early", global_output_tristate, 1'b0);
    chb("set reset early", global_set_reset, 1'b0);
    chb("write early", global_write_enable, 1'b1);
    chb("end flag held", end_of_startup_flag, 1'b0);
    hold_low <= 1'b0;
    step(3);
    rd(OFS_STATUS, 32'h7, 32'h7, RESP_OKAY);
    chb("end flag", end_of_startup_flag, 1'b1);
    chb("pins to user", config_pins_user_io, 1'b1);
    chb("byte port off", byte_port_active, 1'b0);
    prog();
    wr(OFS_CLOCK, 32'h0000_000c, RESP_OKAY);
    wr(OFS_PHASE, 32'h0012_8884, RESP_OKAY);
    go(1'b1);
    step(4);
    rd(OFS_STATUS, 32'h7, 32'h2, RESP_OKAY);
    chb("pin wait", global_output_tristate, 1'b1);
    lk <= 1'b1;
    step(10);
    chb("pin go", global_output_tristate, 1'b0);
    chb("end after lock", end_of_startup_flag, 1'b1);
    chb("done driven", done_o & done_oe, 1'b1);
    prog();
    go(1'b0);
    chb("crc fault", init_oe, 1'b1);
    step(2);
    rd(OFS_STATUS, 32'h7, 32'h0, RESP_OKAY);
    prog();
    wr(OFS_CLOCK, 32'h0000_0010, RESP_OKAY);
    chb("clock drive", configuration_clock_oe, 1'b1);
    per(2 * INIT_HALF);
    bytes(59);
    per(2 * INIT_HALF);
    bytes(1);
    per(10);
    wr(OFS_CLOCK, 32'h0, RESP_OKAY);
    wr(OFS_SECURE, 32'h1, RESP_OKAY);
    chb("scan readback", scan_readback_allow, 1'b0);
    chb("byte readback", byte_port_readback_allow, 1'b0);
    chb("scan config", scan_config_allow, 1'b1);
    wr(OFS_SECURE, 32'h2, RESP_OKAY);
    chb("scan cfg lock", scan_config_allow, 1'b0);
    chb("byte cfg lock", byte_port_config_allow, 1'b0);
    wr(OFS_SECURE, 32'h0, RESP_OKAY);
    rd(OFS_SECURE, 32'h3, 32'h2, RESP_OKAY);
    prog();
    chb("sec cleared", scan_config_allow, 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
